// ===== verilog/crs_pkg.sv
/*
 Shared constants, types and the state record of the clock and reset sequencer.
 Assumes one 50 MHz reference clock that stands in for the oscillator clock.
*/
package crs_pkg;
   localparam int          CLK_NS       = 20;
   localparam logic [7:0]  MCC_IDX      = 8'h38;
   localparam logic [7:0]  TRIM_IDX     = 8'h39;
   localparam logic [7:0]  STAT_IDX     = 8'h3a;
   localparam logic [7:0]  MCC_ADDR     = 8'(MCC_IDX * 4);
   localparam logic [7:0]  TRIM_ADDR    = 8'(TRIM_IDX * 4);
   localparam logic [7:0]  STAT_ADDR    = 8'(STAT_IDX * 4);
   localparam int          SMS_BIT      = 0;
   localparam int          MCO_BIT      = 1;
   localparam int          LOCK_BIT     = 3;
   localparam logic [1:0]  MCC_RST      = 2'h0;
   localparam logic [7:0]  TRIM_RST     = 8'hff;
   localparam int          SLOW_DIV     = 32;
   localparam int          RST_DLY_CYC  = 256;
   localparam int          FETCH_CYC    = 2;
   localparam logic [15:0] RST_VEC      = 16'hfffe;
   localparam logic [3:0]  PLL_MULT     = 4'h8;

   typedef enum logic [1:0] {
      CRS_OSC_EXT,
      CRS_OSC_RC,
      CRS_OSC_PLL
   } crs_osc_t;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_ACTIVE,
      ST_DELAY,
      ST_FETCH,
      ST_PLLWAIT,
      ST_HALT
   } crs_state_t;

   typedef struct packed {
      crs_state_t  st;
      logic [15:0] cnt;
      logic [2:0]  sync;
      logic [15:0] pulse;
      logic        armed;
      logic        src_ext;
      logic [1:0]  mcc;
      logic [7:0]  trim;
      logic        locked;
      logic        pll_en;
      logic        rc_en;
      logic [4:0]  div;
      logic        cpu_en;
      logic        clk_valid;
      logic        core_rst;
      logic        rst_oe;
      logic        pin_lvl;
      logic        vec_fetch;
      logic [15:0] vec_addr;
      logic        waitreq;
      logic [7:0]  rdata;
      crs_osc_t    osc;
      logic        pll_run;
   } crs_regs_t;

   // Power-up starts a full reset sequence that drives the reset pin low.
   localparam crs_regs_t CRS_RST = '{
      st: ST_ACTIVE, cnt: 16'h0000, sync: 3'h7, pulse: 16'h0000,
      armed: 1'b0, src_ext: 1'b0, mcc: MCC_RST, trim: TRIM_RST,
      locked: 1'b0, pll_en: 1'b0, rc_en: 1'b0, div: 5'h00,
      cpu_en: 1'b0, clk_valid: 1'b0, core_rst: 1'b1, rst_oe: 1'b1,
      pin_lvl: 1'b0, vec_fetch: 1'b0, vec_addr: 16'h0000,
      waitreq: 1'b1, rdata: 8'h00, osc: CRS_OSC_EXT, pll_run: 1'b0};

   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
endpackage

// ===== verilog/crs_seq.sv
/*
 Clock and reset sequencer: clock control registers on Avalon-MM, slow-mode
 CPU clock enable, PLL start-up and lock, and the reset sequence with the
 open-drain reset pin. Assumes option straps and core events on ref_clk.
*/
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps

//Function
// - With PLL enabled, the clock is delivered only after the PLL start-up delay.
// - Hardware sets lock flag at bit 3 when locked, clears otherwise.
// - Bit 1 drives main clock onto its pin; reset clears it.
// - Bit 0 selects CPU clock as oscillator or oscillator divided by 32.
// - Trim 00h is fastest, FFh slowest; trim resets to FFh.
// - Reset sources are pin pulse, watchdog and illegal opcode.
// - Every source acts on the pin, held low during the delay.
// - Sequence: active phase, 256 CPU clock delay, vector fetch.
// - Vector fetch lasts two cycles from FFFEh and FFFFh.
// - With PLL enabled, start-up delay follows the reset sequence.
// - Reset pin is an input and an open-drain output.
// - External pulse of minimum width is detected even during halt.
// - Watchdog overflow starts a full reset sequence.
// - PLL multiplies the 1 MHz clock by 8.
// - Without PLL, RC gives 1 MHz, else external clock direct.
module crs_seq #(
   parameter int PLL_STARTUP_NS = 1000,
   parameter int MIN_PULSE_NS   = 100,
   parameter int ACTIVE_CYC     = 16
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        rst_pin_i,
   output logic             rst_pin_o,
   output logic             rst_pin_oe_o,
   input  wire logic        wdog_ovf_i,
   input  wire logic        illegal_op_i,
   input  wire logic        halt_i,
   input  wire logic        pll_opt_i,
   input  wire logic        rc_opt_i,
   output logic             core_rst_o,
   output logic             vec_fetch_o,
   output logic [15:0]      vec_addr_o,
   output logic             cpu_clk_en_o,
   output logic             clk_valid_o,
   output logic             pll_run_o,
   output logic [3:0]       pll_mult_o,
   output logic [1:0]       osc_src_o,
   output logic [7:0]       rc_trim_o,
   output logic             mco_en_o
);
   localparam int STARTUP_CYC = crs_pkg::cyc_up(PLL_STARTUP_NS);
   localparam int PULSE_CYC   = crs_pkg::cyc_up(MIN_PULSE_NS);

   crs_pkg::crs_regs_t s;
   crs_pkg::crs_regs_t next_s;
   logic               pin_low;
   logic               pin_high;
   logic               req;
   logic               acc;
   logic               in_rst;
   logic               trig;
   logic [7:0]         rd_mux;
   logic               sel_mcc;
   logic               sel_trim;
   logic               sel_stat;
   logic               wr_take;
   logic               int_src;
   logic               pin_src;
   logic               run_next;

   always_comb begin
      next_s = s;
      next_s.sync = {s.sync[1:0], rst_pin_i};
      // Only agreeing late stages count, so a glitch in one sample is ignored.
      pin_low = !s.sync[1] && !s.sync[2];
      pin_high = s.sync[1] && s.sync[2];
      in_rst = (s.st == crs_pkg::ST_ACTIVE) || (s.st == crs_pkg::ST_DELAY) ||
               (s.st == crs_pkg::ST_FETCH);

      sel_mcc = (avs_address_i == crs_pkg::MCC_ADDR);
      sel_trim = (avs_address_i == crs_pkg::TRIM_ADDR);
      sel_stat = (avs_address_i == crs_pkg::STAT_ADDR);

      // Unmapped addresses fall through to zero, as do all reserved bits.
      rd_mux = 8'h00;
      if (sel_mcc) begin
         rd_mux = {6'h00, s.mcc};
      end
      if (sel_trim) begin
         rd_mux = s.trim;
      end
      if (sel_stat) begin
         rd_mux = 8'(s.locked) << crs_pkg::LOCK_BIT;
      end
      req = avs_read_i || avs_write_i;
      acc = req && !s.waitreq;
      wr_take = acc && avs_write_i && avs_byteenable_i[0];
      next_s.waitreq = !(req && s.waitreq);
      if (req && s.waitreq) begin
         next_s.rdata = rd_mux;
      end
      // The status register has no writable bit, so a write to it is dropped.
      if (wr_take && sel_mcc) begin
         next_s.mcc = avs_writedata_i[1:0];
      end
      if (wr_take && sel_trim) begin
         next_s.trim = avs_writedata_i[7:0];
      end
      if (in_rst) begin
         next_s.mcc = crs_pkg::MCC_RST;
         next_s.trim = crs_pkg::TRIM_RST;
      end

      // Pin is armed only after it is seen high, so our own drive is not a source.
      if (pin_high && !s.rst_oe) begin
         next_s.armed = 1'b1;
      end
      if (pin_low && s.armed && !s.rst_oe) begin
         if (s.pulse != 16'(PULSE_CYC)) begin
            next_s.pulse = s.pulse + 16'h0001;
         end
      end else begin
         next_s.pulse = 16'h0000;
      end
      int_src = wdog_ovf_i || illegal_op_i;
      pin_src = (s.pulse == 16'(PULSE_CYC));
      trig = int_src || pin_src;

      next_s.cpu_en = 1'b0;
      next_s.vec_fetch = 1'b0;
      case (s.st)
         crs_pkg::ST_ACTIVE: begin
            next_s.core_rst = 1'b1;
            next_s.clk_valid = 1'b0;
            next_s.locked = 1'b0;
            next_s.pll_en = pll_opt_i;
            next_s.rc_en = rc_opt_i;
            next_s.rst_oe = !s.src_ext;
            next_s.cnt = s.cnt + 16'h0001;
            if (s.src_ext ? pin_high : (s.cnt == 16'(ACTIVE_CYC - 1))) begin
               next_s.st = crs_pkg::ST_DELAY;
               next_s.cnt = 16'h0000;
               next_s.rst_oe = 1'b1;
            end
         end
         crs_pkg::ST_DELAY: begin
            next_s.cpu_en = 1'b1;
            next_s.cnt = s.cnt + 16'h0001;
            if (s.cnt == 16'(crs_pkg::RST_DLY_CYC - 1)) begin
               next_s.st = crs_pkg::ST_FETCH;
               next_s.cnt = 16'h0000;
               next_s.rst_oe = 1'b0;
               next_s.vec_fetch = 1'b1;
               next_s.vec_addr = crs_pkg::RST_VEC;
            end
         end
         crs_pkg::ST_FETCH: begin
            next_s.cpu_en = 1'b1;
            next_s.vec_fetch = 1'b1;
            next_s.vec_addr = crs_pkg::RST_VEC + 16'h0001;
            next_s.cnt = s.cnt + 16'h0001;
            if (s.cnt == 16'(crs_pkg::FETCH_CYC - 1)) begin
               next_s.vec_fetch = 1'b0;
               next_s.vec_addr = 16'h0000;
               next_s.core_rst = 1'b0;
               next_s.cnt = 16'h0000;
               next_s.st = s.pll_en ? crs_pkg::ST_PLLWAIT : crs_pkg::ST_RUN;
               next_s.clk_valid = !s.pll_en;
            end
         end
         crs_pkg::ST_PLLWAIT: begin
            next_s.cnt = s.cnt + 16'h0001;
            if (s.cnt == 16'(STARTUP_CYC - 1)) begin
               next_s.st = crs_pkg::ST_RUN;
               next_s.clk_valid = 1'b1;
               next_s.locked = 1'b1;
               next_s.cnt = 16'h0000;
            end
         end
         crs_pkg::ST_HALT: begin
            if (!halt_i) begin
               next_s.st = s.pll_en ? crs_pkg::ST_PLLWAIT : crs_pkg::ST_RUN;
               next_s.clk_valid = !s.pll_en;
               next_s.cnt = 16'h0000;
            end
         end
         crs_pkg::ST_RUN: begin
            // Slow mode trades CPU speed for power; the divider restarts on each change.
            if (s.mcc[crs_pkg::SMS_BIT]) begin
               next_s.div = s.div + 5'h01;
               next_s.cpu_en = (s.div == 5'(crs_pkg::SLOW_DIV - 1));
            end else begin
               next_s.div = 5'h00;
               next_s.cpu_en = 1'b1;
            end
            if (halt_i) begin
               next_s.st = crs_pkg::ST_HALT;
               next_s.clk_valid = 1'b0;
               next_s.cpu_en = 1'b0;
               next_s.locked = 1'b0;
            end
         end
         default: next_s.st = crs_pkg::ST_ACTIVE;
      endcase

      if (trig && (s.st != crs_pkg::ST_ACTIVE) && (s.st != crs_pkg::ST_DELAY)) begin
         next_s.st = crs_pkg::ST_ACTIVE;
         next_s.src_ext = !int_src;
         next_s.rst_oe = int_src;
         next_s.armed = 1'b0;
         next_s.pulse = 16'h0000;
         next_s.cnt = 16'h0000;
         next_s.core_rst = 1'b1;
         next_s.clk_valid = 1'b0;
         next_s.cpu_en = 1'b0;
         next_s.locked = 1'b0;
         next_s.vec_fetch = 1'b0;
         next_s.vec_addr = 16'h0000;
         next_s.div = 5'h00;
      end

      if (s.pll_en) begin
         next_s.osc = crs_pkg::CRS_OSC_PLL;
      end else if (s.rc_en) begin
         next_s.osc = crs_pkg::CRS_OSC_RC;
      end else begin
         next_s.osc = crs_pkg::CRS_OSC_EXT;
      end
      // Registered so that the PLL enable sees no decode glitch.
      run_next = (next_s.st == crs_pkg::ST_RUN) || (next_s.st == crs_pkg::ST_PLLWAIT);
      next_s.pll_run = next_s.pll_en && run_next;
      next_s.pin_lvl = 1'b0;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s <= crs_pkg::CRS_RST;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata_o    = {24'h000000, s.rdata};
   assign avs_waitrequest_o = s.waitreq;
   assign rst_pin_o         = s.pin_lvl;
   assign rst_pin_oe_o      = s.rst_oe;
   assign core_rst_o        = s.core_rst;
   assign vec_fetch_o       = s.vec_fetch;
   assign vec_addr_o        = s.vec_addr;
   assign cpu_clk_en_o      = s.cpu_en;
   assign clk_valid_o       = s.clk_valid;
   assign pll_run_o         = s.pll_run;
   assign pll_mult_o        = crs_pkg::PLL_MULT;
   assign osc_src_o         = s.osc;
   assign rc_trim_o         = s.trim;
   assign mco_en_o          = s.mcc[crs_pkg::MCO_BIT];
endmodule

// ===== test/crs_seq_monitor.sv
/* Port assertions for the clock and reset sequencer.
 Assumes a bind onto crs_seq from the bench top. */
`timescale 1ns/10ps
module crs_seq_monitor (
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  avs_address_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic        rst_pin_oe_o,
   input wire logic        wdog_ovf_i,
   input wire logic        illegal_op_i,
   input wire logic        halt_i,
   input wire logic        core_rst_o,
   input wire logic        vec_fetch_o,
   input wire logic [15:0] vec_addr_o,
   input wire logic        cpu_clk_en_o,
   input wire logic        clk_valid_o,
   input wire logic [3:0]  pll_mult_o
);
   logic [15:0] low_n;
   logic [7:0]  gap;
   logic        st_rd;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   assign st_rd = !avs_waitrequest_o && avs_address_i == crs_pkg::STAT_ADDR;
   // Gaps are cleared while halted or not running, so a wakeup cannot look like a stall.
   always_ff @(posedge ref_clk_i) begin
      low_n <= (rst_i || !rst_pin_oe_o) ? 16'h0000 : low_n + 16'h0001;
      gap   <= (rst_i || cpu_clk_en_o || halt_i || !clk_valid_o) ? 8'h00 : gap + 8'h01;
   end
   sequence s_fetch;
      vec_addr_o == 16'hfffe ##1 vec_fetch_o && vec_addr_o == 16'hffff ##1 !vec_fetch_o;
   endsequence
   a_oe_in_reset: assert property (rst_pin_oe_o |-> core_rst_o)
      else $error("pin pulled outside reset");
   a_fetch_pair: assert property ($rose(vec_fetch_o) |-> s_fetch)
      else $error("vector fetch sequence wrong");
   a_delay_then_fetch: assert property ($fell(rst_pin_oe_o) |-> vec_fetch_o)
      else $error("delay not followed by fetch");
   a_delay_len: assert property ($rose(vec_fetch_o) |-> low_n >= 16'd256)
      else $error("delay phase too short");
   a_no_clk_reset: assert property (core_rst_o |-> !clk_valid_o)
      else $error("clock delivered during reset");
   a_src_restart: assert property ((wdog_ovf_i || illegal_op_i) && !core_rst_o
      |-> ##[1:2] rst_pin_oe_o)
      else $error("reset source ignored");
   a_cpu_gap: assert property (clk_valid_o && !halt_i |-> gap < 8'd32)
      else $error("cpu clock gap too long");
   a_stat_rsvd: assert property (st_rd |-> (avs_readdata_o & 32'hfffffff7) == 32'h0)
      else $error("reserved status bits set");
   a_lock_reset: assert property (st_rd && core_rst_o && $past(core_rst_o)
      |-> avs_readdata_o == 32'h0)
      else $error("lock flag set during reset");
   a_pll_mult: assert property (pll_mult_o == 4'h8)
      else $error("pll multiplier wrong");
endmodule

// ===== test/crs_rst_ext.sv
/* External reset circuitry on the open-drain reset pin.
 Assumes the bench commands pulls; the pin idles high through the pull-up. */
`timescale 1ns/10ps
module crs_rst_ext (
   input  wire logic pull_i,
   input  wire logic oe_i,
   output logic      pin_o
);
   // Either party pulling wins; released, the weak pull-up lifts the pin.
   assign pin_o = !(pull_i || oe_i);
endmodule

// ===== test/tb_clock_and_reset_sequencer.sv
/* Self-checking bench for crs_seq with its reset pin partner.
 Assumes the package constants and a 50 MHz reference clock. */
`timescale 1ns/10ps
module tb_clock_and_reset_sequencer;
   typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} crs_row_t;
   logic        clk = 0, rst = 1, rd = 0, wr = 0, pull = 0, wd = 0, il = 0, halt = 0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdat = 32'h0, q, rdat;
   logic        wreq, pin, oe, crst, vf, cen, valid, prun, clock_out_enable;
   logic [15:0] va;
   logic [3:0]  mult;
   logic [1:0]  osc;
   logic [7:0]  trim;
   int          n_errors = 0, n_compared = 0, n;
   crs_row_t    rows [6] = '{'{8'he0, 8'h03, 8'h03}, '{8'he0, 8'hff, 8'h03},
      '{8'he4, 8'h80, 8'h80}, '{8'he8, 8'hff, 8'h08}, '{8'he4, 8'h00, 8'h00},
      '{8'h00, 8'h5a, 8'h00}};
   crs_seq #(.ACTIVE_CYC(4)) DUT (.ref_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'h1),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .rst_pin_i(pin), .rst_pin_o(),
      .rst_pin_oe_o(oe), .wdog_ovf_i(wd), .illegal_op_i(il), .halt_i(halt),
      .pll_opt_i(1'b1), .rc_opt_i(1'b1), .core_rst_o(crst), .vec_fetch_o(vf),
      .vec_addr_o(va), .cpu_clk_en_o(cen), .clk_valid_o(valid), .pll_run_o(prun),
      .pll_mult_o(mult), .osc_src_o(osc), .rc_trim_o(trim), .mco_en_o(clock_out_enable));
   crs_rst_ext u_ext (.pull_i(pull), .oe_i(oe), .pin_o(pin));
   initial forever #10 clk = !clk;
   task complete_run;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   // The request is held until the rising edge at which waitrequest is seen low.
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 100);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 100) n_errors++;
   endtask
   task wait_valid;
      repeat (2000) begin
         @(negedge clk);
         if (valid === 1'b1) break;
      end
      chk("clk_valid", 1, valid);
   endtask
   task count(input int cyc, input logic s);
      n = 0;
      repeat (cyc) begin
         @(negedge clk);
         if ((s ? oe : cen) === 1'b1) n++;
         else if (s && n > 0) break;
      end
   endtask
   initial begin
      #400000;
      n_errors++;
      complete_run;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(0, 8'he4, 0);
      chk("trim_rst", 32'hff, q);
      bus(0, 8'he0, 0);
      chk("mcc_rst", 32'h0, q);
      bus(0, 8'he8, 0);
      chk("stat_rst", 32'h0, q);
      wait_valid;
      chk("osc_src", 2, osc);
      foreach (rows[i]) begin
         bus(1, rows[i].a, rows[i].w);
         bus(0, rows[i].a, 0);
         chk("reg", rows[i].e, q);
      end
      chk("mco_on", 1, clock_out_enable);
      chk("trim_out", 0, trim);
      count(320, 0);
      chk("slow_en", 10, n);
      bus(1, 8'he0, 8'h00);
      @(posedge clk);
      count(64, 0);
      chk("fast_en", 64, n);
      chk("mco_off", 0, clock_out_enable);
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         wd <= (s == 0);
         il <= (s == 1);
         @(posedge clk);
         wd <= 1'b0;
         il <= 1'b0;
         count(600, 1);
         chk("pin_low", 260, n);
         wait_valid;
         bus(0, 8'he4, 0);
         chk("trim_again", 32'hff, q);
         bus(1, 8'he4, 8'h80);
         bus(0, 8'he4, 0);
         chk("trim_cal", 32'h80, q);
      end
      @(posedge clk);
      halt <= 1'b1;
      pull <= 1'b1;
      repeat (10) @(posedge clk);
      pull <= 1'b0;
      @(negedge clk);
      chk("ext_rst", 1, crst);
      bus(0, 8'he8, 0);
      chk("lock_off", 32'h0, q);
      halt <= 1'b0;
      wait_valid;
      bus(0, 8'he8, 0);
      chk("lock_on", 32'h08, q);
      complete_run;
   end
endmodule
bind crs_seq crs_seq_monitor u_mon (.ref_clk_i, .rst_i, .avs_address_i, .avs_readdata_o,
   .avs_waitrequest_o, .rst_pin_oe_o, .wdog_ovf_i, .illegal_op_i, .halt_i, .core_rst_o,
   .vec_fetch_o, .vec_addr_o, .cpu_clk_en_o, .clk_valid_o, .pll_mult_o);
